// ==== design/fpt_pipe_ctrl.sv ====
// floating-point issue, interlock and stall control plus straddle stores
// assumes integer pipe shares clock_in and rst_n_in; inputs are same-domain
`default_nettype none
// Behaviour
// RULE1: straddling store uses two address and memory flows
// RULE2: next instruction waits extra address cycle
// RULE3: simple classes issue every cycle, latency four
// RULE4: consumers wait for producer latency
// RULE5: double multiply uses stage one twice
// RULE6: instruction behind two-cycle op is held
// RULE7: decode, four stages, writeback one later
// RULE8: divider results go through register file
// RULE9: divide durations typical and worst given
// RULE10: async divide runs in background, slip
// RULE11: synchronous divide stalls whole pipeline
// RULE12: branch on fp condition waits writeback
// RULE13: compare flags usable four cycles after issue
// RULE14: fp load adds one load-use cycle
// RULE15: denormal single load stalls per shifted bit
// RULE16: single zero load adds one latency cycle
// RULE17: store data read only from register file
// RULE18: denormal single store has no penalty
// RULE19: enabled exceptions or record stall memory stage
// RULE20: integer and fp pipes advance independently
// RULE21: exception or record groups sync, stall integer
// RULE22: compare condition updates without stall
// RULE23: reset clears valids, divider, counters
module fpt_pipe_ctrl (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire fpt_pkg::fpt_issue_type issue_in,
  input wire fpt_pkg::fpt_mode_type mode_in,
  input wire logic [7:0] div_cycles_in,
  input wire logic load_sp_zero_in,
  input wire logic [4:0] load_denorm_shift_in,
  input wire logic load_done_in,
  input wire logic store_valid_in,
  input wire logic [2:0] store_addr_low_in,
  input wire logic [3:0] store_size_in,
  input wire logic int_mem_stall_in,
  output logic fp_issue_ack_out,
  output logic fp_stall_out,
  output logic int_stall_out,
  output logic addr_hold_out,
  output logic [1:0] store_flow_out,
  output logic cache_write_out,
  output logic store_data_rf_out,
  output logic [3:0] fp_stage_valid_out,
  output logic fp_writeback_out,
  output logic [4:0] fp_writeback_reg_out,
  output logic cond_ready_out,
  output logic cond_update_out,
  output logic [2:0] mispredict_pen_out
);
  logic [3:0] stage_q;
  logic [3:0] stage_d;
  logic [4:0] dst0_q, dst1_q, dst2_q, dst3_q;
  logic cmp0_q, cmp1_q, cmp2_q, cmp3_q;
  logic fw_q;
  logic [4:0] fw_reg_q;
  logic hold_q;
  logic [31:0] busy_q;
  logic [31:0] ready_q;
  logic [7:0] dn_q;
  logic straddle_q;
  logic [1:0] flow_q;
  logic addr_hold_q;
  logic wr_q;
  logic sync_q;
  logic div_start;
  logic div_busy;
  logic div_done;
  logic [4:0] div_dest;
  logic div_async;
  logic div_sync_stall;
  logic src_wait;
  logic issue_ok;
  logic exc_sync;
  logic crosses;
  logic [4:0] end_byte;
  logic stall;
  logic slip;
  logic is_div;

  assign is_div = issue_in.op == fpt_pkg::FPT_OP_DDIV ||
                  issue_in.op == fpt_pkg::FPT_OP_SDIV;

  // RULE10 background divide condition
  assign div_async = mode_in.async_divide_allow_bit && !mode_in.any_exc_en &&
                     !issue_in.record_condition_bit;

  // RULE4 operand scoreboard wait
  assign src_wait = busy_q[issue_in.src_a] || busy_q[issue_in.src_b];

  // RULE11 sync divide stall
  assign div_sync_stall = div_busy && !sync_q;
  // RULE10 slip for divider write
  assign slip = div_done && sync_q;
  // RULE11 RULE15 sync divide or denormal normalisation stall
  assign stall = div_sync_stall || (dn_q != 8'h00);

  // RULE3 RULE6 issue interval gating
  assign issue_ok = issue_in.valid && !stall && !hold_q && !src_wait &&
                    !slip && !(is_div && div_busy);

  assign div_start = issue_ok && is_div;

  // RULE19 exception sync condition
  assign exc_sync = issue_ok && issue_in.op != fpt_pkg::FPT_OP_LOAD &&
                    issue_in.op != fpt_pkg::FPT_OP_STORE &&
                    (mode_in.inexact_en || mode_in.underflow_en ||
                     mode_in.overflow_en || mode_in.any_exc_en ||
                     issue_in.record_condition_bit);

  fpt_div_seq u_div (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .start_in(div_start),
    .cycles_in(div_cycles_in),
    .dest_in(issue_in.dest),
    .busy_out(div_busy),
    .done_out(div_done),
    .dest_out(div_dest)
  );

  // RULE5 double multiply holds stage one a second cycle
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      hold_q <= 1'b0;
    else
      hold_q <= issue_ok && issue_in.op == fpt_pkg::FPT_OP_DMUL;
  end

  // RULE7 stage advance, four execution stages
  always_comb
  begin
    stage_d = stage_q;
    if (!stall)
    begin
      stage_d = {stage_q[2:0],
                 issue_ok && !is_div && issue_in.op != fpt_pkg::FPT_OP_STORE};
      if (hold_q)
      begin
        stage_d[0] = stage_q[0];
        stage_d[1] = 1'b0;
      end
    end
  end

  // RULE23 reset clears stage valids
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stage_q <= 4'h0;
      dst0_q <= 5'h00;
      dst1_q <= 5'h00;
      dst2_q <= 5'h00;
      dst3_q <= 5'h00;
      cmp0_q <= 1'b0;
      cmp1_q <= 1'b0;
      cmp2_q <= 1'b0;
      cmp3_q <= 1'b0;
    end
    else if (!stall)
    begin
      stage_q <= stage_d;
      if (!hold_q)
      begin
        dst0_q <= issue_in.dest;
        cmp0_q <= issue_ok && issue_in.op == fpt_pkg::FPT_OP_CMP;
        dst1_q <= dst0_q;
        cmp1_q <= cmp0_q;
      end
      else
        cmp1_q <= 1'b0;
      dst2_q <= dst1_q;
      dst3_q <= dst2_q;
      cmp2_q <= cmp1_q;
      cmp3_q <= cmp2_q;
    end
  end

  // RULE8 divider writes register file only
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fw_q <= 1'b0;
      fw_reg_q <= 5'h00;
    end
    else if (div_done)
    begin
      fw_q <= 1'b1;
      fw_reg_q <= div_dest;
    end
    else
    begin
      fw_q <= stage_q[3] && !stall;
      fw_reg_q <= dst3_q;
    end
  end

  // RULE4 RULE16 RULE14 scoreboard of pending results
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      busy_q <= fpt_pkg::FPT_SCORE_RESET;
      ready_q <= fpt_pkg::FPT_SCORE_RESET;
    end
    else
    begin
      ready_q <= fpt_pkg::FPT_SCORE_RESET;
      if (fw_q)
        ready_q[fw_reg_q] <= 1'b1;
      if (ready_q != 32'h0)
        busy_q <= busy_q & ~ready_q;
      // RULE16 zero load is not released at load done, waits for writeback release
      if (load_done_in && !load_sp_zero_in)
        busy_q[issue_in.dest] <= 1'b0;
      if (issue_ok && issue_in.op != fpt_pkg::FPT_OP_STORE &&
          issue_in.op != fpt_pkg::FPT_OP_CMP)
        busy_q[issue_in.dest] <= 1'b1;
    end
  end

  // RULE15 one bit per cycle normalisation count
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      dn_q <= fpt_pkg::FPT_CNT_RESET;
    else if (dn_q != 8'h00)
      dn_q <= dn_q - 8'h01;
    else if (load_done_in && load_denorm_shift_in != 5'h00)
      dn_q <= {3'h0, load_denorm_shift_in};
  end

  // RULE10 background divide flag, set at async divide start and held while divider busy
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      sync_q <= 1'b0;
    else
      sync_q <= div_async && div_start ? 1'b1 : (div_busy ? sync_q : 1'b0);
  end

  // RULE1 straddle detect on eight-byte boundary
  assign end_byte = {2'b00, store_addr_low_in} + {1'b0, store_size_in} - 5'h01;
  assign crosses = store_valid_in && store_size_in != 4'h0 &&
                   end_byte >= 5'(fpt_pkg::FPT_DW_BYTES);

  // RULE2 extra address cycle after straddle
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      flow_q <= 2'b00;
      straddle_q <= 1'b0;
      addr_hold_q <= 1'b0;
      wr_q <= 1'b0;
    end
    else
    begin
      straddle_q <= flow_q == 2'b01;
      wr_q <= store_valid_in;
      if (crosses && flow_q == 2'b00)
        flow_q <= 2'b01;
      else if (flow_q == 2'b01)
        flow_q <= 2'b10;
      else
        flow_q <= 2'b00;
      addr_hold_q <= (crosses && flow_q == 2'b00) || flow_q == 2'b01;
    end
  end

  // RULE19 RULE20 RULE21 integer stall on sync groups, sync divide and denormal stalls
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      int_stall_out <= 1'b0;
      fp_stall_out <= 1'b0;
      fp_issue_ack_out <= 1'b0;
    end
    else
    begin
      int_stall_out <= exc_sync || stall;
      fp_stall_out <= stall || (int_mem_stall_in && exc_sync);
      fp_issue_ack_out <= issue_ok;
    end
  end

  // RULE12 RULE13 RULE22 compare flag timing
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cond_ready_out <= 1'b0;
      cond_update_out <= 1'b0;
      mispredict_pen_out <= 3'h0;
    end
    else
    begin
      cond_update_out <= cmp2_q && !stall;
      cond_ready_out <= cmp3_q && !stall;
      mispredict_pen_out <= cmp0_q ? 3'(fpt_pkg::FPT_MISPREDICT_PEN) : 3'h0;
    end
  end

  // RULE17 RULE18 store data from register file, no extra cycles
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      store_data_rf_out <= 1'b0;
      cache_write_out <= 1'b0;
      store_flow_out <= 2'b00;
      addr_hold_out <= 1'b0;
    end
    else
    begin
      store_data_rf_out <= wr_q && !src_wait;
      cache_write_out <= wr_q || straddle_q;
      store_flow_out <= flow_q;
      addr_hold_out <= addr_hold_q;
    end
  end

  assign fp_stage_valid_out = stage_q;
  assign fp_writeback_out = fw_q;
  assign fp_writeback_reg_out = fw_reg_q;
endmodule : fpt_pipe_ctrl
`default_nettype wire

// ==== include/fpt_pkg.sv ====
// package for the floating-point pipeline timing control block
// assumes one core clock and active-low asynchronous reset everywhere
`default_nettype none
package fpt_pkg;
  // operation classes seen at floating-point issue
  typedef enum logic [2:0] {
    FPT_OP_SIMPLE,
    FPT_OP_DMUL,
    FPT_OP_DDIV,
    FPT_OP_SDIV,
    FPT_OP_CMP,
    FPT_OP_LOAD,
    FPT_OP_STORE
  } fpt_op_type;

  // issue request from decode
  typedef struct packed {
    logic valid;
    fpt_op_type op;
    logic record_condition_bit;
    logic [4:0] dest;
    logic [4:0] src_a;
    logic [4:0] src_b;
  } fpt_issue_type;

  // mode and exception-enable bits
  typedef struct packed {
    logic async_divide_allow_bit;
    logic non_ieee_mode_bit;
    logic inexact_en;
    logic underflow_en;
    logic overflow_en;
    logic any_exc_en;
  } fpt_mode_type;

  localparam int unsigned FPT_LAT_SIMPLE = 4;
  localparam int unsigned FPT_LAT_DMUL = 5;
  localparam int unsigned FPT_II_DMUL = 2;
  localparam int unsigned FPT_LAT_CMP_BRANCH = 4;
  localparam int unsigned FPT_MISPREDICT_PEN = 6;
  localparam int unsigned FPT_STRADDLE_II = 3;
  localparam int unsigned FPT_DW_BYTES = 8;
  localparam int unsigned FPT_DIV_D_TYP = 34;
  localparam int unsigned FPT_DIV_D_MAX = 140;
  localparam int unsigned FPT_DIV_S_TYP = 20;
  localparam int unsigned FPT_DIV_S_MAX = 66;
  localparam int unsigned FPT_DENORM_MAX = 23;
  localparam int unsigned FPT_ZERO_EXTRA = 1;
  localparam int unsigned FPT_FPLOAD_EXTRA = 1;
  localparam logic [7:0] FPT_CNT_RESET = 8'h00;
  localparam logic [31:0] FPT_SCORE_RESET = 32'h0;
endpackage : fpt_pkg
`default_nettype wire

// ==== design/fpt_div_seq.sv ====
// divide sequencer: counts issue cycles of one divide
// assumes the cycle count is given by the execution datapath at start
`default_nettype none
module fpt_div_seq (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic [7:0] cycles_in,
  input wire logic [4:0] dest_in,
  output logic busy_out,
  output logic done_out,
  output logic [4:0] dest_out
);
  logic [7:0] cnt_q;
  logic [4:0] dest_q;
  logic done_q;

  // RULE9 divide duration count
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q <= fpt_pkg::FPT_CNT_RESET;
      dest_q <= 5'h00;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (start_in && cnt_q == 8'h00)
      begin
        cnt_q <= (cycles_in == 8'h00) ? 8'h01 : cycles_in;
        dest_q <= dest_in;
      end
      else if (cnt_q != 8'h00)
      begin
        cnt_q <= cnt_q - 8'h01;
        done_q <= (cnt_q == 8'h01);
      end
    end
  end

  assign busy_out = (cnt_q != 8'h00);
  assign done_out = done_q;
  assign dest_out = dest_q;
endmodule : fpt_div_seq
`default_nettype wire

// ==== tb/fpt_pipe_ctrl_monitor.sv ====
// port checker for the fp pipeline control block
// assumes it is bound onto fpt_pipe_ctrl in the one core clock domain
`default_nettype none
module fpt_mon (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire fpt_pkg::fpt_issue_type issue_in,
  input wire fpt_pkg::fpt_mode_type mode_in,
  input wire logic fp_issue_ack_out,
  input wire logic fp_stall_out,
  input wire logic int_stall_out,
  input wire logic addr_hold_out,
  input wire logic [1:0] store_flow_out,
  input wire logic fp_writeback_out,
  input wire logic cond_ready_out,
  input wire logic cond_update_out,
  input wire logic [2:0] mispredict_pen_out,
  input wire logic [3:0] fp_stage_valid_out
);
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  fpt_pkg::fpt_op_type op_q;
  logic plain_q;
  // latency figures only hold with no exception or record sync
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      op_q <= fpt_pkg::FPT_OP_SIMPLE;
      plain_q <= 1'b0;
    end
    else
    begin
      op_q <= issue_in.op;
      plain_q <= !mode_in.any_exc_en && !mode_in.inexact_en &&
        !issue_in.record_condition_bit;
    end
  end
  AST_RESET_CLEAR: assert property ($rose(rst_n_in) |->
    fp_stage_valid_out == 4'h0 && !fp_stall_out && !int_stall_out)
    else $error("outputs not clear after reset");
  AST_SIMPLE_LAT: assert property (fp_issue_ack_out && plain_q &&
    op_q == fpt_pkg::FPT_OP_SIMPLE |-> ##4 fp_writeback_out)
    else $error("simple op writeback late");
  AST_DMUL_LAT: assert property (fp_issue_ack_out && plain_q &&
    op_q == fpt_pkg::FPT_OP_DMUL |-> ##5 fp_writeback_out)
    else $error("double multiply writeback late");
  AST_DMUL_GAP: assert property (fp_issue_ack_out &&
    op_q == fpt_pkg::FPT_OP_DMUL |=> !fp_issue_ack_out)
    else $error("issue right behind double multiply");
  AST_CMP_READY: assert property (fp_issue_ack_out && plain_q &&
    op_q == fpt_pkg::FPT_OP_CMP |-> ##4 cond_ready_out)
    else $error("compare flags not ready in time");
  AST_CMP_UPDATE: assert property (fp_issue_ack_out && plain_q &&
    op_q == fpt_pkg::FPT_OP_CMP |-> ##3 cond_update_out &&
    !fp_stall_out && !int_stall_out)
    else $error("compare condition update late or stalled");
  AST_CMP_PEN: assert property (fp_issue_ack_out &&
    op_q == fpt_pkg::FPT_OP_CMP |=> mispredict_pen_out == 3'h6)
    else $error("wrong mispredict penalty");
  AST_STRADDLE: assert property (store_flow_out == 2'h1 |=>
    store_flow_out == 2'h2)
    else $error("second store flow missing");
  AST_HOLD_TWO: assert property ($rose(addr_hold_out) |=>
    addr_hold_out ##1 !addr_hold_out)
    else $error("address hold not two cycles");
  AST_SYNC_DIV: assert property (fp_issue_ack_out &&
    op_q == fpt_pkg::FPT_OP_DDIV &&
    !$past(mode_in.async_divide_allow_bit) |-> ##[0:2] fp_stall_out)
    else $error("synchronous divide did not stall");
endmodule : fpt_mon
bind fpt_pipe_ctrl fpt_mon fpt_mon_i (.clock_in, .rst_n_in, .issue_in,
  .mode_in, .fp_issue_ack_out, .fp_stall_out, .int_stall_out,
  .addr_hold_out, .store_flow_out, .fp_writeback_out, .cond_ready_out,
  .cond_update_out, .mispredict_pen_out, .fp_stage_valid_out);
`default_nettype wire

// ==== tb/fpt_int_model.sv ====
// integer load/store pipe model facing the fp control block
// assumes the bench requests a store with go_in at the falling edge
`default_nettype none
module fpt_int_model (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic go_in,
  input wire logic [2:0] addr_in,
  input wire logic [3:0] size_in,
  input wire logic addr_hold_in,
  input wire logic int_stall_in,
  output logic store_valid_out,
  output logic [2:0] store_addr_low_out,
  output logic [3:0] store_size_out,
  output logic int_mem_stall_out
);
  // stores move regardless of fp stalls
  always_ff @(negedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      store_valid_out <= 1'b0;
      store_addr_low_out <= 3'h0;
      store_size_out <= 4'h0;
    end
    else if (go_in && !addr_hold_in)
    begin
      store_valid_out <= 1'b1;
      store_addr_low_out <= addr_in;
      store_size_out <= size_in;
    end
    else
    begin
      // idle fields flip so a stale value is never trusted
      store_valid_out <= 1'b0;
      store_addr_low_out <= ~store_addr_low_out;
      store_size_out <= ~store_size_out;
    end
  end
  assign int_mem_stall_out = int_stall_in;
endmodule : fpt_int_model
`default_nettype wire

// ==== tb/tb_fpt_pipe_ctrl.sv ====
// self-checking bench for fpt_pipe_ctrl with the integer pipe model
// assumes package, design and checker compiled first
`default_nettype none
module tb_fpt_pipe_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {fpt_pkg::fpt_op_type op; int w; int lat;} fpt_row_type;
  fpt_row_type rows[3] = '{'{fpt_pkg::FPT_OP_SIMPLE, 0,
    fpt_pkg::FPT_LAT_SIMPLE}, '{fpt_pkg::FPT_OP_DMUL, 0,
    fpt_pkg::FPT_LAT_DMUL}, '{fpt_pkg::FPT_OP_CMP, 1,
    fpt_pkg::FPT_LAT_CMP_BRANCH}};
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  fpt_pkg::fpt_issue_type issue = '0;
  fpt_pkg::fpt_mode_type mode = '0;
  logic [7:0] div_cyc = 8'h22;
  logic go = 1'b0;
  logic [2:0] s_addr = 3'h0;
  logic ld_done = 1'b0;
  logic [4:0] ld_shift = 5'h00;
  logic [2:0] sa;
  logic [3:0] ss;
  logic [1:0] flow;
  logic [4:0] wreg;
  logic sv, ims, ack, fst, ist, ahold, cw, wb, crdy;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0, n, m;
  always #10 clock_in = ~clock_in;
  fpt_pipe_ctrl fpt_pipe_ctrl_i (.clock_in, .rst_n_in, .issue_in(issue),
    .mode_in(mode), .div_cycles_in(div_cyc), .load_sp_zero_in(1'b0),
    .load_denorm_shift_in(ld_shift), .load_done_in(ld_done),
    .store_valid_in(sv), .store_addr_low_in(sa), .store_size_in(ss),
    .int_mem_stall_in(ims), .fp_issue_ack_out(ack), .fp_stall_out(fst),
    .int_stall_out(ist), .addr_hold_out(ahold), .store_flow_out(flow),
    .cache_write_out(cw), .store_data_rf_out(), .fp_stage_valid_out(),
    .fp_writeback_out(wb), .fp_writeback_reg_out(wreg),
    .cond_ready_out(crdy), .cond_update_out(), .mispredict_pen_out());
  fpt_int_model fpt_int_model_i (.clock_in, .rst_n_in, .go_in(go),
    .addr_in(s_addr), .size_in(4'h4), .addr_hold_in(ahold),
    .int_stall_in(ist), .store_valid_out(sv), .store_addr_low_out(sa),
    .store_size_out(ss), .int_mem_stall_out(ims));
  task automatic end_of_test();
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  // the run should need about 400 cycles
  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      failures++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  // issue held until ack; t0 is the accepting edge
  task automatic fire(input fpt_pkg::fpt_op_type op, input logic [4:0] d,
    input logic rec);
    issue <= '{1'b1, op, rec, d, 5'h01, 5'h02};
    n = 0;
    do @(negedge clock_in); while (ack !== 1'b1 && ++n < 200);
    chk("issue ack", ack, 1);
    t0 = cyc;
    issue.valid <= 1'b0;
  endtask : fire
  task automatic count_for(input int k);
    n = 0;
    m = 0;
    repeat (k)
    begin
      @(negedge clock_in);
      n += (fst === 1'b1) + (cw === 1'b1);
      m += (ahold === 1'b1) + (ist === 1'b1);
    end
  endtask : count_for
  task automatic store(input logic [2:0] a, input int exp_cw, exp_hold);
    go <= 1'b1;
    s_addr <= a;
    @(negedge clock_in);
    go <= 1'b0;
    count_for(8);
    chk("cache writes", n, exp_cw);
    chk("addr hold cycles", m, exp_hold);
  endtask : store
  initial
  begin
    repeat (2) @(negedge clock_in);
    chk("ack in reset", ack, 0);
    chk("stall in reset", fst, 0);
    rst_n_in <= 1'b1;
    @(negedge clock_in);
    foreach (rows[i])
    begin
      fire(rows[i].op, 5'(i + 3), 1'b0);
      n = 0;
      while ((rows[i].w ? crdy : wb) !== 1'b1 && ++n < 50)
        @(negedge clock_in);
      chk("latency", cyc - t0, rows[i].lat);
      if (rows[i].w == 0)
        chk("writeback reg", wreg, 5'(i + 3));
      repeat (3) @(negedge clock_in);
    end
    store(3'h6, 2, 2);
    store(3'h0, 1, 0);
    mode <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    fire(fpt_pkg::FPT_OP_SIMPLE, 5'h07, 1'b0);
    // sync stall shows with the ack, so look before draining
    chk("exc sync int stall", ist, 1);
    count_for(8);
    mode <= '0;
    fire(fpt_pkg::FPT_OP_SIMPLE, 5'h08, 1'b1);
    chk("record sync int stall", ist, 1);
    count_for(8);
    mode.async_divide_allow_bit <= 1'b1;
    fire(fpt_pkg::FPT_OP_DDIV, 5'h09, 1'b0);
    count_for(10);
    chk("async divide stall", n, 0);
    repeat (160) @(negedge clock_in);
    mode <= '0;
    fire(fpt_pkg::FPT_OP_DDIV, 5'h0a, 1'b0);
    count_for(160);
    chk("sync divide stall", n > 0, 1);
    chk("stall released", fst, 0);
    ld_shift <= 5'h05;
    ld_done <= 1'b1;
    @(negedge clock_in);
    ld_done <= 1'b0;
    count_for(8);
    chk("denormal fp stall cycles", n, 5);
    chk("denormal int stall cycles", m, 5);
    end_of_test();
  end
endmodule : tb_fpt_pipe_ctrl
`default_nettype wire
